// file: hbp_pkg.sv
// Shared constants and carrier types for the host bus port.
package hbp_pkg;
   localparam int ADDR_W = 22;
   localparam int DATA_W = 16;
   localparam int REG_BLOCK_BYTES = 128;
   localparam int REG_OFS_W = $clog2(REG_BLOCK_BYTES);
   localparam int REG_IDX_W = REG_OFS_W - 1;
   localparam int PHASE_DIV = 2;
   localparam logic [1:0] WRITE_WAIT_STATES = 2'h2;
   localparam logic SYNC_MODE_PIN_LEVEL = 1'h1;
   localparam logic MIO_MEMORY = 1'h1;

   typedef struct packed {
      logic chipSelectN;
      logic readStrobeN;
      logic writeStrobeN;
      logic memOrIoSelect;
      logic upperByteSelectN;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } hbp_host_pins_type;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
      logic addrOe;
      logic dataOe;
      logic ctrlOe;
      logic readStrobeN;
      logic writeStrobeN;
      logic memOrIoSelect;
      logic upperByteSelectN;
   } hbp_host_drive_type;

   typedef struct packed {
      logic valid;
      logic write;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } hbp_int_req_type;

   typedef struct packed {
      logic wrEn;
      logic rdEn;
      logic [REG_IDX_W-1:0] wordIdx;
      logic [DATA_W-1:0] wdata;
   } hbp_reg_access_type;

   typedef struct packed {
      logic req;
      logic write;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic lowByteWriteStrobeN;
      logic highByteWriteStrobeN;
   } hbp_gm_access_type;

   typedef enum logic [1:0] {
      S_IDLE = 2'b00,
      S_WRWAIT = 2'b01,
      S_RDWAIT = 2'b10,
      S_ACK = 2'b11
   } hbp_slave_state_type;

   typedef enum logic [1:0] {
      M_IDLE = 2'b00,
      M_REQ = 2'b01,
      M_DRIVE = 2'b10,
      M_RELEASE = 2'b11
   } hbp_master_state_type;
endpackage

// file: hbp_sync.sv
// Two-stage synchroniser for a bundle of asynchronous pin levels.
module hbp_sync #(
   parameter int W = 1
) (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic [W-1:0] pinIn,
   input wire logic [W-1:0] resetLevel,
   output logic [W-1:0] syncOut
);
   typedef struct packed {
      logic [W-1:0] stage1;
      logic [W-1:0] stage2;
   } hbp_sync_state_type;

   hbp_sync_state_type st;
   hbp_sync_state_type next_st;

   // The first stage feeds only the second stage.
   always_comb begin
      next_st.stage1 = pinIn;
      next_st.stage2 = st.stage1;
   end

   // The reset value is a constant tie at the instance, never a live signal.
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         st.stage1 <= resetLevel;
         st.stage2 <= resetLevel;
      end else begin
         st <= next_st;
      end
   end

   assign syncOut = st.stage2;
endmodule

// file: hbp_phase_div.sv
// Divider giving the internal system clock rate as a one-cycle enable.
module hbp_phase_div #(
   parameter int RATIO = 2
) (
   input wire logic clk_sys,
   input wire logic srst,
   output logic phaseTick
);
   typedef struct packed {
      logic [$clog2(RATIO)-1:0] count;
      logic tick;
   } hbp_div_state_type;

   localparam logic [$clog2(RATIO)-1:0] LAST = ($clog2(RATIO))'(RATIO - 1);

   hbp_div_state_type st;
   hbp_div_state_type next_st;

   always_comb begin
      next_st = st;
      next_st.tick = (st.count == LAST);
      next_st.count = (st.count == LAST) ? '0 : st.count + 1'b1;
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign phaseTick = st.tick;
endmodule

// file: hbp_host_port.sv
// Host bus port: slave access decode, byte pairing and bus master handshake.

//////////////////////////////////////////////////////////////////////////////
module hbp_host_port import hbp_pkg::*; (
   input wire logic clk_sys,
   input wire logic srst,
   input wire hbp_host_pins_type hostPins,
   input wire logic hold_grant_in,
   input wire logic extBusReady,
   input wire logic [ADDR_W-1:0] gfxMemLimit,
   input wire logic [ADDR_W-1:REG_OFS_W] regBlockBase,
   input wire logic regBlockIsIo,
   input wire logic host_width_select,
   input wire hbp_int_req_type intReq,
   output logic intReqToGraphics,
   output logic intDone,
   output logic [DATA_W-1:0] intRdata,
   output hbp_reg_access_type regAccess,
   input wire logic [DATA_W-1:0] regRdata,
   output hbp_gm_access_type gmAccess,
   input wire logic gmDone,
   input wire logic [DATA_W-1:0] gmRdata,
   output hbp_host_drive_type hostDrive,
   output logic bus_request_out,
   output logic master_bus_enable,
   output logic slave_cycle_enable,
   output logic syncModeActive
);
   typedef struct packed {
      hbp_slave_state_type slaveSt;
      hbp_master_state_type masterSt;
      logic [1:0] waitCnt;
      logic readIsReg;
      logic slaveRead;
      logic lowValid;
      logic [7:0] lowByte;
      logic [ADDR_W-1:1] lowAddr;
      logic syncMode;
      logic [2:0] prevReset;
      logic prevRd;
      logic prevWr;
      logic prevGrant;
      logic [DATA_W-1:0] slaveData;
      hbp_int_req_type mReq;
      logic [DATA_W-1:0] mRdata;
      logic mDone;
      hbp_reg_access_type regOp;
      hbp_gm_access_type gm;
   } hbp_port_state_type;

   hbp_port_state_type st;
   hbp_port_state_type next_st;
   hbp_host_pins_type host;
   logic [1:0] grantSync;
   logic phaseTick;
   logic rdCmd;
   logic wrCmd;
   logic grantSeen;
   logic regHit;
   logic gmHit;
   logic wide;
   logic isOdd;

   //////////////////////////////////////////////////////////////////////////
   hbp_sync #(
      .W($bits(hbp_host_pins_type))
   ) u_host_sync (
      .clk_sys(clk_sys),
      .srst(srst),
      .pinIn(hostPins),
      .resetLevel({5'h1e, {ADDR_W{1'b0}}, {DATA_W{1'b0}}}),
      .syncOut(host)
   );

   hbp_sync #(
      .W(2)
   ) u_grant_sync (
      .clk_sys(clk_sys),
      .srst(srst),
      .pinIn({hold_grant_in, extBusReady}),
      .resetLevel(2'h0),
      .syncOut(grantSync)
   );

   hbp_phase_div #(
      .RATIO(PHASE_DIV)
   ) u_phase (
      .clk_sys(clk_sys),
      .srst(srst),
      .phaseTick(phaseTick)
   );

   //////////////////////////////////////////////////////////////////////////
   // Asynchronous mode demands two agreeing samples, trading a phase of
   // latency for immunity to a strobe caught mid-transition.
   always_comb begin
      rdCmd = !host.chipSelectN && !host.readStrobeN;
      wrCmd = !host.chipSelectN && !host.writeStrobeN;
      if (!st.syncMode) begin
         rdCmd = rdCmd && st.prevRd;
         wrCmd = wrCmd && st.prevWr;
      end
      grantSeen = st.syncMode ? grantSync[1] : (grantSync[1] && st.prevGrant);
      regHit = (host.addr[ADDR_W-1:REG_OFS_W] == regBlockBase)
         && (host.memOrIoSelect == (regBlockIsIo ? !MIO_MEMORY : MIO_MEMORY));
      gmHit = !regHit && (host.memOrIoSelect == MIO_MEMORY)
         && (host.addr < gfxMemLimit);
      wide = host_width_select;
      isOdd = host.addr[0] && !wide;
   end

   //////////////////////////////////////////////////////////////////////////
   always_comb begin
      next_st = st;
      next_st.prevReset = {st.prevReset[1:0], srst};
      next_st.regOp.wrEn = 1'b0;
      next_st.regOp.rdEn = 1'b0;
      next_st.mDone = 1'b0;
      // The strap is taken two clocks after release, when the pin synchroniser
      // holds real pin samples instead of its reset level.
      if (st.prevReset[2] && !st.prevReset[1]) begin
         next_st.syncMode = (host.upperByteSelectN == SYNC_MODE_PIN_LEVEL);
      end
      // Read data is caught on any clock, since memory may answer between ticks.
      if (st.gm.req && gmDone) begin
         next_st.gm.req = 1'b0;
         next_st.gm.lowByteWriteStrobeN = 1'b1;
         next_st.gm.highByteWriteStrobeN = 1'b1;
         if (!st.gm.write) begin
            next_st.slaveData = gmRdata;
         end
      end
      if (phaseTick) begin
         next_st.prevRd = !host.chipSelectN && !host.readStrobeN;
         next_st.prevWr = !host.chipSelectN && !host.writeStrobeN;
         next_st.prevGrant = grantSync[1];
         // Slave engine runs regardless of the master engine's wait for grant.
         unique case (st.slaveSt)
            S_IDLE: begin
               if (st.masterSt != M_DRIVE && (rdCmd || wrCmd) && (regHit || gmHit)) begin
                  next_st.slaveRead = rdCmd;
                  next_st.readIsReg = regHit;
                  if (wrCmd) begin
                     next_st.slaveSt = S_WRWAIT;
                     next_st.waitCnt = 2'h1;
                     if (regHit && (wide || !host.addr[0])) begin
                        if (wide) begin
                           next_st.regOp.wrEn = 1'b1;
                           next_st.regOp.wdata = host.data;
                        end else begin
                           next_st.lowValid = 1'b1;
                           next_st.lowByte = host.data[7:0];
                           next_st.lowAddr = host.addr[ADDR_W-1:1];
                        end
                     end else if (regHit) begin
                        if (st.lowValid && st.lowAddr == host.addr[ADDR_W-1:1]) begin
                           next_st.regOp.wrEn = 1'b1;
                           next_st.regOp.wdata = {host.data[15:8], st.lowByte};
                        end
                        next_st.lowValid = 1'b0;
                     end else begin
                        next_st.gm.req = 1'b1;
                        next_st.gm.write = 1'b1;
                        next_st.gm.addr = host.addr;
                        next_st.gm.wdata = host.data;
                        next_st.gm.lowByteWriteStrobeN = host.addr[0];
                        next_st.gm.highByteWriteStrobeN = host.upperByteSelectN;
                     end
                  end else begin
                     next_st.slaveSt = S_RDWAIT;
                     if (regHit) begin
                        next_st.regOp.rdEn = 1'b1;
                     end else begin
                        next_st.gm.req = 1'b1;
                        next_st.gm.write = 1'b0;
                        next_st.gm.addr = host.addr;
                     end
                  end
                  next_st.regOp.wordIdx = host.addr[REG_OFS_W-1:1];
                  if (wide) begin
                     next_st.regOp.wordIdx = host.addr[REG_OFS_W-1:1];
                  end
               end
            end
            S_WRWAIT: begin
               next_st.waitCnt = st.waitCnt + 2'h1;
               if (st.waitCnt == WRITE_WAIT_STATES) begin
                  next_st.slaveSt = S_ACK;
               end
            end
            S_RDWAIT: begin
               if (st.readIsReg) begin
                  next_st.slaveData = regRdata;
                  next_st.slaveSt = S_ACK;
               end else if (!st.gm.req || gmDone) begin
                  next_st.slaveSt = S_ACK;
               end
            end
            S_ACK: begin
               if (!rdCmd && !wrCmd) begin
                  next_st.slaveSt = S_IDLE;
               end
            end
         endcase
         unique case (st.masterSt)
            M_IDLE: begin
               if (intReq.valid && intReq.addr >= gfxMemLimit) begin
                  next_st.mReq = intReq;
                  next_st.masterSt = M_REQ;
               end
            end
            M_REQ: begin
               if (grantSeen) begin
                  next_st.masterSt = M_DRIVE;
               end
            end
            M_DRIVE: begin
               if (!grantSeen) begin
                  next_st.masterSt = M_RELEASE;
               end else if (grantSync[0]) begin
                  next_st.mRdata = host.data;
                  next_st.mDone = 1'b1;
                  next_st.masterSt = M_RELEASE;
               end
            end
            M_RELEASE: begin
               next_st.masterSt = M_IDLE;
            end
         endcase
         if (isOdd && st.slaveSt == S_IDLE) begin
            next_st.regOp.wordIdx = host.addr[REG_OFS_W-1:1];
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         st <= '0;
         st.prevReset <= '1;
         st.syncMode <= 1'b1;
         st.gm.lowByteWriteStrobeN <= 1'b1;
         st.gm.highByteWriteStrobeN <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // An aborted master cycle gives no done pulse; the requester keeps
   // its request up and the engine asks for the bus again.
   always_comb begin
      hostDrive = '0;
      hostDrive.readStrobeN = 1'b1;
      hostDrive.writeStrobeN = 1'b1;
      hostDrive.upperByteSelectN = 1'b1;
      hostDrive.addr = st.mReq.addr;
      hostDrive.data = st.slaveData;
      if (st.masterSt == M_DRIVE) begin
         hostDrive.addrOe = 1'b1;
         hostDrive.ctrlOe = 1'b1;
         hostDrive.dataOe = st.mReq.write;
         hostDrive.data = st.mReq.data;
         hostDrive.readStrobeN = st.mReq.write;
         hostDrive.writeStrobeN = !st.mReq.write;
         hostDrive.memOrIoSelect = MIO_MEMORY;
         hostDrive.upperByteSelectN = 1'b0;
      end else if (st.slaveSt == S_ACK && st.slaveRead) begin
         hostDrive.dataOe = 1'b1;
      end
   end

   assign bus_request_out = (st.masterSt == M_REQ) || (st.masterSt == M_DRIVE);
   assign master_bus_enable = (st.masterSt == M_DRIVE);
   assign slave_cycle_enable = (st.slaveSt == S_ACK);
   assign intReqToGraphics = intReq.valid && (intReq.addr < gfxMemLimit);
   assign intDone = st.mDone;
   assign intRdata = st.mRdata;
   assign regAccess = st.regOp;
   assign gmAccess = st.gm;
   assign syncModeActive = st.syncMode;
endmodule

// file: hbp_host_port_chk.sv
// Concurrent checks on the ports of the host bus port.
module hbp_host_port_chk import hbp_pkg::*; (
   input wire logic clk_sys,
   input wire logic srst,
   input wire hbp_host_pins_type hostPins,
   input wire logic hold_grant_in,
   input wire hbp_int_req_type intReq,
   input wire logic [ADDR_W-1:0] gfxMemLimit,
   input wire logic intReqToGraphics,
   input wire logic intDone,
   input wire hbp_reg_access_type regAccess,
   input wire hbp_gm_access_type gmAccess,
   input wire hbp_host_drive_type hostDrive,
   input wire logic bus_request_out,
   input wire logic master_bus_enable,
   input wire logic slave_cycle_enable,
   input wire logic syncModeActive
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (srst);
   //////////////////////////////////////////////////////////////////////////////
   gfx_route_a: assert property (intReqToGraphics == (intReq.valid && intReq.addr < gfxMemLimit))
      else $error("graphics routing flag wrong");
   mben_has_req_a: assert property (master_bus_enable |-> bus_request_out)
      else $error("bus enable without request");
   bus_oe_master_a: assert property ((hostDrive.addrOe || hostDrive.ctrlOe) |-> master_bus_enable)
      else $error("bus lines driven while not master");
   grant_first_a: assert property ($rose(master_bus_enable) |-> $past(hold_grant_in, 2))
      else $error("bus taken before grant");
   grant_loss_a: assert property (master_bus_enable && !hold_grant_in |-> ##[1:10] !bus_request_out)
      else $error("request kept after grant loss");
   done_master_a: assert property (intDone |-> $past(master_bus_enable))
      else $error("master done without bus");
   sen_needs_cs_a: assert property ($rose(slave_cycle_enable) |-> !$past(hostPins.chipSelectN, 3))
      else $error("slave answer without chip select");
   sen_release_a: assert property (slave_cycle_enable && hostPins.readStrobeN && hostPins.writeStrobeN
      |-> ##[1:12] !slave_cycle_enable)
      else $error("slave answer not ended");
   write_wait_a: assert property (regAccess.wrEn || ($rose(gmAccess.req) && gmAccess.write)
      |-> ##[4:8] slave_cycle_enable)
      else $error("write answer late");
   read_strobes_a: assert property (gmAccess.req && !gmAccess.write
      |-> gmAccess.lowByteWriteStrobeN && gmAccess.highByteWriteStrobeN)
      else $error("byte strobe on read");
   mode_hold_a: assert property (!$past(srst) && !$past(srst, 2) && !$past(srst, 3)
      && !$past(srst, 4) |-> $stable(syncModeActive))
      else $error("interface mode changed");
   cover property (regAccess.wrEn);
   cover property ($rose(master_bus_enable));
   cover property (slave_cycle_enable && bus_request_out && !master_bus_enable);
   cover property (master_bus_enable && !hold_grant_in);
endmodule

bind hbp_host_port hbp_host_port_chk hbp_host_port_chk_i (.clk_sys, .srst, .hostPins, .hold_grant_in,
   .intReq, .gfxMemLimit, .intReqToGraphics, .intDone, .regAccess, .gmAccess, .hostDrive,
   .bus_request_out, .master_bus_enable, .slave_cycle_enable, .syncModeActive);

// file: hbp_bus_model.sv
// Behavioural owner of the shared system bus answering bus requests.
module hbp_bus_model (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic bus_request_out,
   input wire logic master_bus_enable,
   input wire logic [7:0] grantDelay,
   input wire logic dropOnce,
   output logic hold_grant_in,
   output logic extBusReady
);
   logic [7:0] waitCnt;
   logic lost, spent;
   //////////////////////////////////////////////////////////////////////////////
   // After a forced loss no new grant comes until the request drops, so a port that
   // keeps requesting hangs here and the bench timeout catches it.
   always_ff @(posedge clk_sys) begin
      if (!dropOnce) spent <= 1'h0;
      if (srst || !bus_request_out) begin
         hold_grant_in <= 1'h0;
         extBusReady <= 1'h0;
         waitCnt <= 8'h00;
         lost <= 1'h0;
      end else if (!hold_grant_in) begin
         waitCnt <= waitCnt + 8'h01;
         if (!lost && waitCnt >= grantDelay) hold_grant_in <= 1'h1;
      end else if (master_bus_enable && dropOnce && !spent) begin
         hold_grant_in <= 1'h0;
         lost <= 1'h1;
         spent <= 1'h1;
      end else if (master_bus_enable) begin
         extBusReady <= 1'h1;
      end
   end
endmodule

// file: hbp_host_port_bench.sv
// Self-checking bench for the host bus port.
module hbp_host_port_bench import hbp_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [21:0] RB = 22'h3fff80;
   logic clk_sys, srst, hold_grant_in, extBusReady, regBlockIsIo, host_width_select, gmDone;
   logic intReqToGraphics, intDone, bus_request_out, master_bus_enable, slave_cycle_enable;
   logic syncModeActive, dropOnce;
   logic [7:0] grantDelay;
   logic [5:0] idx;
   logic [15:0] d;
   logic [ADDR_W-1:0] gfxMemLimit;
   logic [ADDR_W-1:REG_OFS_W] regBlockBase;
   logic [DATA_W-1:0] intRdata, regRdata, gmRdata;
   hbp_host_pins_type hp, hostPins;
   hbp_host_drive_type hostDrive;
   hbp_int_req_type intReq;
   hbp_reg_access_type regAccess;
   hbp_gm_access_type gmAccess;
   logic [31:0] expQ[$];
   int err_count, checks, cyc;
   //////////////////////////////////////////////////////////////////////////////
   hbp_host_port hbp_host_port_i (.clk_sys, .srst, .hostPins, .hold_grant_in, .extBusReady,
      .gfxMemLimit, .regBlockBase, .regBlockIsIo, .host_width_select, .intReq, .intReqToGraphics,
      .intDone, .intRdata, .regAccess, .regRdata, .gmAccess, .gmDone, .gmRdata, .hostDrive,
      .bus_request_out, .master_bus_enable, .slave_cycle_enable, .syncModeActive);
   hbp_bus_model hbp_bus_model_i (.clk_sys, .srst, .bus_request_out, .master_bus_enable,
      .grantDelay, .dropOnce, .hold_grant_in, .extBusReady);
   // The pins seen by the port are the wire levels of all drivers.
   always_comb begin
      hostPins = hp;
      if (hostDrive.addrOe) hostPins.addr = hostDrive.addr;
      if (hostDrive.dataOe) hostPins.data = hostDrive.data;
      if (hostDrive.ctrlOe) begin
         hostPins.readStrobeN = hostDrive.readStrobeN;
         hostPins.writeStrobeN = hostDrive.writeStrobeN;
         hostPins.memOrIoSelect = hostDrive.memOrIoSelect;
         hostPins.upperByteSelectN = hostDrive.upperByteSelectN;
      end
   end
   assign regRdata = {regAccess.wordIdx, ~regAccess.wordIdx, 4'h9};
   initial begin
      clk_sys = 1'h0;
      forever #10 clk_sys = ~clk_sys;
   end
   //////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic take(input logic [31:0] seen);
      if (expQ.size() == 0) chk("unexpected result", seen, 32'h0);
      else chk("result", seen, expQ.pop_front());
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // Graphics memory answers one cycle after a request; the watcher notes each result.
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      gmDone <= gmAccess.req && !gmDone;
      if (regAccess.wrEn === 1'h1) take({10'h040, regAccess.wordIdx, regAccess.wdata});
      if ($rose(gmAccess.req) && gmAccess.write === 1'h1) take({14'h0800,
         gmAccess.highByteWriteStrobeN, gmAccess.lowByteWriteStrobeN, gmAccess.wdata});
      if ($rose(master_bus_enable)) take({10'h0c0, hostDrive.addr});
      if ($rose(slave_cycle_enable) && hostDrive.dataOe === 1'h1)
         take({16'h0100, hostDrive.data});
      if (cyc == 20000) begin
         err_count++;
         end_of_test();
      end
   end
   task automatic waitFor(input logic v);
      int n;
      n = 0;
      while (slave_cycle_enable !== v && n < 300) begin
         @(negedge clk_sys);
         n++;
      end
      if (n == 300) chk("slave answer", 32'h0, 32'h1);
   endtask
   task automatic acc(input logic rd, input logic [21:0] a, input logic [15:0] v,
         input logic ub, input logic mem_or_io_select);
      @(posedge clk_sys);
      hp <= '{1'h0, ~rd, rd, mem_or_io_select, ub, a, v};
      waitFor(1'h1);
      @(posedge clk_sys);
      hp <= '{1'h1, 1'h1, 1'h1, 1'h1, 1'h1, ~a, ~v};
      waitFor(1'h0);
   endtask
   task automatic pair(input logic [5:0] i, input logic [15:0] v);
      expQ.push_back({10'h040, i, v});
      acc(1'h0, {RB[21:7], i, 1'h0}, {~v[15:8], v[7:0]}, 1'h1, 1'h0);
      acc(1'h0, {RB[21:7], i, 1'h1}, {v[15:8], ~v[7:0]}, 1'h0, 1'h0);
   endtask
   task automatic mst(input logic [21:0] a);
      int n;
      @(posedge clk_sys);
      intReq <= '{1'h1, 1'h1, a, 16'h5a3c};
      n = 0;
      while (intDone !== 1'h1 && n < 500) begin
         @(negedge clk_sys);
         n++;
      end
      chk("master data", {16'h0, intRdata}, 32'h5a3c);
      @(posedge clk_sys);
      intReq <= '0;
   endtask
   task automatic rst(input logic ub);
      @(posedge clk_sys);
      srst <= 1'h1;
      hp <= '{1'h1, 1'h1, 1'h1, 1'h1, ub, 22'h0, 16'h0};
      host_width_select <= 1'h0;
      repeat (6) @(posedge clk_sys);
      srst <= 1'h0;
      repeat (8) @(negedge clk_sys);
      chk("interface mode", {31'h0, syncModeActive}, {31'h0, ub});
   endtask
   //////////////////////////////////////////////////////////////////////////////
   initial begin
      srst = 1'h1;
      hp = '{1'h1, 1'h1, 1'h1, 1'h1, 1'h1, 22'h0, 16'h0};
      intReq = '0;
      gfxMemLimit = 22'h200000;
      regBlockBase = RB[21:7];
      regBlockIsIo = 1'h1;
      host_width_select = 1'h0;
      gmRdata = 16'hc35a;
      gmDone = 1'h0;
      grantDelay = 8'h02;
      dropOnce = 1'h0;
      err_count = 0;
      checks = 0;
      cyc = 0;
      void'($urandom(56293));
      rst(1'h1);
      acc(1'h0, {RB[21:7], 6'h01, 1'h0}, 16'h0011, 1'h1, 1'h0);
      pair(6'h01, 16'h3322);
      acc(1'h0, {RB[21:7], 6'h01, 1'h1}, 16'h4400, 1'h0, 1'h0);
      expQ.push_back({16'h0100, 6'h01, 6'h3e, 4'h9});
      acc(1'h1, {RB[21:7], 6'h01, 1'h0}, 16'h0, 1'h1, 1'h0);
      for (int k = 0; k < 3; k++) begin
         idx = 6'($urandom);
         d = 16'($urandom);
         pair(idx, d);
      end
      $display("test done: byte pairing");
      @(posedge clk_sys);
      host_width_select <= 1'h1;
      expQ.push_back({10'h040, 6'h05, 16'hbeef});
      acc(1'h0, {RB[21:7], 6'h05, 1'h1}, 16'hbeef, 1'h0, 1'h0);
      for (int k = 0; k < 3; k++) begin
         d = 16'($urandom);
         expQ.push_back({14'h0800, k[0], k[1], d});
         acc(1'h0, {21'h000080, k[1]}, d, k[0], 1'h1);
      end
      expQ.push_back({16'h0100, 16'hc35a});
      acc(1'h1, 22'h000105, 16'h0, 1'h0, 1'h1);
      $display("test done: word and memory access");
      @(posedge clk_sys);
      intReq <= '{1'h1, 1'h0, 22'h1ffffe, 16'h0};
      @(negedge clk_sys);
      chk("graphics route", {31'h0, intReqToGraphics}, 32'h1);
      @(posedge clk_sys);
      intReq <= '0;
      expQ.push_back({10'h0c0, 22'h200000});
      mst(22'h200000);
      @(posedge clk_sys);
      grantDelay <= 8'h50;
      expQ.push_back({10'h040, 6'h07, 16'h1234});
      expQ.push_back({10'h0c0, 22'h300000});
      fork
         mst(22'h300000);
         begin
            repeat (4) @(posedge clk_sys);
            acc(1'h0, {RB[21:7], 6'h07, 1'h0}, 16'h1234, 1'h0, 1'h0);
         end
      join
      @(posedge clk_sys);
      grantDelay <= 8'h02;
      dropOnce <= 1'h1;
      repeat (2) expQ.push_back({10'h0c0, 22'h3ffffe});
      mst(22'h3ffffe);
      dropOnce <= 1'h0;
      $display("test done: bus mastering");
      rst(1'h0);
      pair(6'h00, 16'h55aa);
      $display("test done: asynchronous mode");
      repeat (20) @(posedge clk_sys);
      chk("pending notes", expQ.size(), 32'h0);
      end_of_test();
   end
endmodule
